/* File: include/ebm_pkg.sv */
// Shared constants and types for the embedded block memory and its user end.
// Assumes both ends run on one clock and import this package.
package ebm_pkg;
   // ****************************************************************
   // Array geometry
   // ****************************************************************
   localparam int EBM_ARRAY_BITS = 9216;
   localparam int EBM_MAX_W = 18;
   localparam int EBM_MAX_AW = 13;
   localparam int EBM_BASE_W = 14;
   localparam int EBM_EMPTY_LVL = 0;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [17:0] EBM_DOUT_RST = 18'h00000;
   localparam logic EBM_FULL_RST = 1'h0;
   localparam logic EBM_AFULL_RST = 1'h0;
   localparam logic EBM_EMPTY_RST = 1'h1;
   localparam logic EBM_AEMPTY_RST = 1'h1;

   // ****************************************************************
   // Reset request field positions
   // ****************************************************************
   localparam int EBM_RK_A = 0;
   localparam int EBM_RK_B = 1;
   localparam int EBM_RK_FIFO = 2;
   localparam int EBM_RK_RPTR = 3;
   localparam int EBM_RK_GLOBAL = 4;
   localparam int EBM_RK_W = 5;
   localparam logic [4:0] EBM_RK_POWERUP = 5'h10;

   typedef enum logic [1:0] {
      EBM_SP = 2'b00,
      EBM_TDP = 2'b01,
      EBM_PDP = 2'b10,
      EBM_FIFO = 2'b11
   } ebm_mode_t;

   typedef enum logic [1:0] {
      EBM_WR_NORMAL = 2'b00,
      EBM_WR_THROUGH = 2'b01,
      EBM_WR_RBW = 2'b10
   } ebm_wmode_t;

   typedef enum logic [1:0] {
      EBM_SEQ_IDLE = 2'b00,
      EBM_SEQ_QUIET = 2'b01,
      EBM_SEQ_APPLY = 2'b10,
      EBM_SEQ_RELEASE = 2'b11
   } ebm_seq_t;

   // Address width that goes with a data width
   function automatic int ebm_aw(input int w);
      case (w)
         1: return 13;
         2: return 12;
         4: return 11;
         9: return 10;
         default: return 9;
      endcase
   endfunction : ebm_aw

   function automatic bit ebm_width_ok(input int w, input bit allow_wide);
      return (w == 1) || (w == 2) || (w == 4) || (w == 9) || (allow_wide && (w == 18));
   endfunction : ebm_width_ok
endpackage : ebm_pkg

/* File: include/ebm_if.sv */
// Connection between the block memory (mem) and the fabric user logic (user).
// Assumes one common clock; all signals are active high unless named _n.
`timescale 1ns/1ps
interface ebm_if;
   import ebm_pkg::*;
   logic a_ce;
   logic a_cs;
   logic a_we;
   logic a_oreg_en;
   logic a_rst;
   logic [EBM_MAX_AW-1:0] a_addr;
   logic [EBM_MAX_W-1:0] a_din;
   logic [EBM_MAX_W-1:0] a_dout;
   logic b_ce;
   logic b_cs;
   logic b_we;
   logic b_oreg_en;
   logic b_rst;
   logic [EBM_MAX_AW-1:0] b_addr;
   logic [EBM_MAX_W-1:0] b_din;
   logic [EBM_MAX_W-1:0] b_dout;
   logic rd_strobe;
   logic read_pointer_reset;
   logic fifo_rst;
   logic global_set_reset_n;
   logic full_flag;
   logic almost_full_flag;
   logic empty_flag;
   logic almost_empty_flag;

   modport mem (
      input a_ce, a_cs, a_we, a_oreg_en, a_rst, a_addr, a_din,
      input b_ce, b_cs, b_we, b_oreg_en, b_rst, b_addr, b_din,
      input rd_strobe, read_pointer_reset, fifo_rst, global_set_reset_n,
      output a_dout, b_dout, full_flag, almost_full_flag, empty_flag, almost_empty_flag
   );

   modport user (
      output a_ce, a_cs, a_we, a_oreg_en, a_rst, a_addr, a_din,
      output b_ce, b_cs, b_we, b_oreg_en, b_rst, b_addr, b_din,
      output rd_strobe, read_pointer_reset, fifo_rst, global_set_reset_n,
      input a_dout, b_dout, full_flag, almost_full_flag, empty_flag, almost_empty_flag
   );
endinterface : ebm_if

/* File: core/ebm_mem.sv */
// Embedded block memory: 9 kb array, RAM modes and a single-clock FIFO.
// Assumes the user end keeps enables low around asynchronous-style resets.
//
// Operation
// [R01] 9 kb array with input and output registers
// [R02] Width shapes per mode, 18 wide only PDP/FIFO
// [R03] Per-port widths, bits packed LSB word zero upward
// [R04] Preloaded contents act as ROM when unwritten
// [R05] Write data and addresses registered before array
// [R06] Output register optional, else array latch directly
// [R07] Ports A and B fully independent
// [R08] Normal mode: output changes on reads only
// [R09] Write-through: written data appears on output
// [R10] Read-before-write: old contents appear on output
// [R11] FIFO write side and read side signal sets
// [R12] Full, almost-full, empty, almost-empty flags registered
// [R13] Programmable flag thresholds, empty fixed zero
// [R14] FIFO reset clears both pointers and flags
// [R15] Read-pointer reset rewinds reader for retransmit
// [R16] Per-port output latch reset, sync or async
// [R17] Global reset clears both output latches
// [R18] User idles enables around asynchronous resets
// [R19] Otherwise reset only with steady clocks
// [R20] Preloaded: global reset off or released early
// [R21] FIFO strobes act as enables for resets
// [R22] Sync reset without global: no sequencing needed
// [R23] Controls active high, sampled rising edge
`timescale 1ns/1ps
module ebm_mem #(
   parameter ebm_pkg::ebm_mode_t MODE = ebm_pkg::EBM_TDP,
   parameter int A_WIDTH = 9,
   parameter int B_WIDTH = 9,
   parameter ebm_pkg::ebm_wmode_t A_WMODE = ebm_pkg::EBM_WR_NORMAL,
   parameter ebm_pkg::ebm_wmode_t B_WMODE = ebm_pkg::EBM_WR_NORMAL,
   parameter bit A_OREG = 1'b0,
   parameter bit B_OREG = 1'b0,
   parameter bit OUT_RST_ASYNC = 1'b0,
   parameter bit GLOBAL_RST_EN = 1'b1,
   parameter int FULL_LVL = 1023,
   parameter int AFULL_LVL = 1000,
   parameter int AEMPTY_LVL = 16,
   parameter logic [9215:0] INIT = '0
) (
   input wire logic CLK,
   input wire logic CE,
   input wire logic RST_N,
   ebm_if.mem M
);
   import ebm_pkg::*;

   // ****************************************************************
   // Configuration checks
   // ****************************************************************
   localparam bit IS_FIFO = (MODE == EBM_FIFO);
   localparam bit WIDE_OK = (MODE == EBM_PDP) || IS_FIFO;
   localparam int FAW = ebm_aw(A_WIDTH);
   localparam int DEPTH = 2 ** FAW;

   if (!ebm_width_ok(A_WIDTH, WIDE_OK) || !ebm_width_ok(B_WIDTH, WIDE_OK))
   begin : g_bad_width
      $error("ebm_mem: port width not supported in this mode"); // [R02]
   end
   if (IS_FIFO && ((A_WIDTH != B_WIDTH) || (FULL_LVL < 1) || (FULL_LVL > DEPTH - 1) ||
      (AFULL_LVL < 1) || (AFULL_LVL > FULL_LVL - 1) ||
      (AEMPTY_LVL < 1) || (AEMPTY_LVL > FULL_LVL - 1)))
   begin : g_bad_fifo
      $error("ebm_mem: FIFO width or flag threshold out of range"); // [R13]
   end

   function automatic int pw(input int p);
      return (p == 0) ? A_WIDTH : B_WIDTH;
   endfunction : pw

   // ****************************************************************
   // Storage and port steering
   // ****************************************************************
   // Contents survive every reset; only configuration loads them
   logic [EBM_ARRAY_BITS-1:0] mem_bits = INIT; // [R01] [R04]
   logic [1:0] p_en, p_we, p_oen, p_rst;
   logic [EBM_MAX_AW-1:0] p_addr [2];
   logic [EBM_MAX_W-1:0] p_din [2];
   logic [1:0] req_reg, we_reg;
   logic [EBM_MAX_AW-1:0] addr_reg [2];
   logic [EBM_MAX_W-1:0] din_reg [2];
   logic [EBM_BASE_W-1:0] base [2];
   logic [EBM_MAX_W-1:0] rd_word [2];
   logic [FAW:0] wp_reg;
   logic [FAW:0] rp_reg;
   logic wr_ok, rd_ok;
   wire logic global_act = ~M.global_set_reset_n & (GLOBAL_RST_EN | IS_FIFO);

   // FIFO: write side rides port A, read side rides port B
   assign p_en[0] = IS_FIFO ? wr_ok : (M.a_ce & M.a_cs); // [R11] [R23]
   assign p_we[0] = IS_FIFO ? 1'b1 : M.a_we;
   assign p_addr[0] = IS_FIFO ? EBM_MAX_AW'(wp_reg[FAW-1:0]) : M.a_addr;
   assign p_din[0] = M.a_din;
   assign p_oen[0] = M.a_oreg_en;
   assign p_rst[0] = IS_FIFO ? 1'b0 : M.a_rst;
   assign p_en[1] = IS_FIFO ? rd_ok : ((MODE != EBM_SP) & M.b_ce & M.b_cs); // [R07]
   assign p_we[1] = (MODE == EBM_TDP) & M.b_we;
   assign p_addr[1] = IS_FIFO ? EBM_MAX_AW'(rp_reg[FAW-1:0]) : M.b_addr;
   assign p_din[1] = M.b_din;
   assign p_oen[1] = M.b_oreg_en;
   assign p_rst[1] = IS_FIFO ? 1'b0 : M.b_rst;

   // ****************************************************************
   // Input registers
   // ****************************************************************
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         req_reg <= '0;
         we_reg <= '0;
         addr_reg <= '{default: '0};
         din_reg <= '{default: '0};
      end else if (CE)
      begin
         req_reg <= p_en; // [R05]
         we_reg <= p_we;
         for (int p = 0; p < 2; p++)
         begin
            if (p_en[p])
            begin
               addr_reg[p] <= p_addr[p]; // [R05]
               din_reg[p] <= p_din[p];
            end
         end
      end
   end

   // Bit offset of a word: word n of width w starts at bit n*w
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         base[p] = EBM_BASE_W'(32'(addr_reg[p]) * pw(p)); // [R03]
         rd_word[p] = '0;
         for (int i = 0; i < EBM_MAX_W; i++)
            if (i < pw(p))
               rd_word[p][i] = mem_bits[base[p] + EBM_BASE_W'(i)];
      end
   end

   // Port B is written last, so it wins an address collision
   always_ff @(posedge CLK)
   begin
      if (CE)
         for (int p = 0; p < 2; p++)
            for (int i = 0; i < EBM_MAX_W; i++)
               if (req_reg[p] && we_reg[p] && (i < pw(p)))
                  mem_bits[base[p] + EBM_BASE_W'(i)] <= din_reg[p][i]; // [R03] [R07]
   end

   // ****************************************************************
   // Output latches and output registers
   // ****************************************************************
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      localparam ebm_wmode_t WM = (p == 0) ? A_WMODE : B_WMODE;
      localparam bit OREG = (p == 0) ? A_OREG : B_OREG;
      localparam logic [EBM_MAX_W-1:0] WMASK = EBM_MAX_W'((1 << pw(p)) - 1);
      logic [EBM_MAX_W-1:0] lat_reg;
      logic [EBM_MAX_W-1:0] lat_next;
      logic [EBM_MAX_W-1:0] out_reg;
      logic [EBM_MAX_W-1:0] dval;
      wire logic clr = p_rst[p] | global_act;

      always_comb
      begin
         lat_next = lat_reg;
         if (req_reg[p] && !we_reg[p])
            lat_next = rd_word[p];
         else if (req_reg[p])
            case (WM)
               EBM_WR_THROUGH: lat_next = din_reg[p] & WMASK; // [R09]
               EBM_WR_RBW: lat_next = rd_word[p]; // [R10]
               default: lat_next = lat_reg; // [R08]
            endcase
      end

      always_ff @(posedge CLK)
      begin
         if (!RST_N)
         begin
            lat_reg <= EBM_DOUT_RST;
            out_reg <= EBM_DOUT_RST;
         end else if (CE)
         begin
            // Clears are taken on an edge like any request; sync ones without global reset need no sequencing
            if (clr)
            begin
               lat_reg <= EBM_DOUT_RST; // [R16] [R17] [R22]
               out_reg <= EBM_DOUT_RST;
            end else
            begin
               lat_reg <= lat_next;
               if (p_oen[p])
                  out_reg <= lat_reg; // [R06]
            end
         end
      end

      // The async option masks the output at once, before the next edge
      assign dval = (OUT_RST_ASYNC && clr) ? EBM_DOUT_RST : (OREG ? out_reg : lat_reg); // [R06] [R16]
      if (p == 0)
      begin : g_a
         assign M.a_dout = dval;
      end else
      begin : g_b
         assign M.b_dout = dval;
      end
   end

   // ****************************************************************
   // FIFO pointers and flags
   // ****************************************************************
   if (IS_FIFO)
   begin : g_fifo
      localparam logic [FAW:0] DEPTH_C = (FAW + 1)'(DEPTH);
      localparam logic [FAW:0] FULL_C = (FAW + 1)'(FULL_LVL);
      localparam logic [FAW:0] AFULL_C = (FAW + 1)'(AFULL_LVL);
      localparam logic [FAW:0] AEMPTY_C = (FAW + 1)'(AEMPTY_LVL);
      localparam logic [FAW:0] EMPTY_C = (FAW + 1)'(EBM_EMPTY_LVL);
      logic full_reg, afull_reg, empty_reg, aempty_reg;
      logic [FAW:0] wp_next, rp_next, cnt_next;
      wire logic [FAW:0] cnt = wp_reg - rp_reg;
      wire logic clear = global_act | M.fifo_rst;

      assign wr_ok = M.a_ce & M.a_we & M.a_cs & (cnt != DEPTH_C); // [R11]
      assign rd_ok = M.b_ce & M.rd_strobe & M.b_cs & (cnt != EMPTY_C); // [R11]
      assign wp_next = wp_reg + (FAW + 1)'(wr_ok);
      // Rewind keeps the lap bit so the count equals what was written this lap
      assign rp_next = M.read_pointer_reset ? {wp_reg[FAW], {FAW{1'b0}}} :
         rp_reg + (FAW + 1)'(rd_ok); // [R15]
      assign cnt_next = wp_next - rp_next;

      always_ff @(posedge CLK)
      begin
         if (!RST_N || (CE && clear))
         begin
            wp_reg <= '0; // [R14]
            rp_reg <= '0;
            full_reg <= EBM_FULL_RST;
            afull_reg <= EBM_AFULL_RST;
            empty_reg <= EBM_EMPTY_RST;
            aempty_reg <= EBM_AEMPTY_RST;
         end else if (CE)
         begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            full_reg <= (cnt_next >= FULL_C); // [R12] [R13]
            afull_reg <= (cnt_next >= AFULL_C);
            empty_reg <= (cnt_next == EMPTY_C);
            aempty_reg <= (cnt_next <= AEMPTY_C);
         end
      end

      assign M.full_flag = full_reg;
      assign M.almost_full_flag = afull_reg;
      assign M.empty_flag = empty_reg;
      assign M.almost_empty_flag = aempty_reg;
   end else
   begin : g_nofifo
      assign {wr_ok, rd_ok} = 2'b00;
      assign wp_reg = '0;
      assign rp_reg = '0;
      assign {M.full_flag, M.almost_full_flag} = {EBM_FULL_RST, EBM_AFULL_RST};
      assign {M.empty_flag, M.almost_empty_flag} = {EBM_EMPTY_RST, EBM_AEMPTY_RST};
   end
endmodule : ebm_mem

/* File: core/ebm_user.sv */
// Fabric-side end of the block memory: forwards user requests and sequences resets.
// Assumes the same clock as the memory end and requests held while BUSY is high.
`timescale 1ns/1ps
module ebm_user (
   input wire logic CLK,
   input wire logic CE,
   input wire logic RST_N,
   input wire logic A_CE,
   input wire logic A_CS,
   input wire logic A_WE,
   input wire logic A_OREG_EN,
   input wire logic [ebm_pkg::EBM_MAX_AW-1:0] A_ADDR,
   input wire logic [ebm_pkg::EBM_MAX_W-1:0] A_DIN,
   output logic [ebm_pkg::EBM_MAX_W-1:0] A_DOUT,
   input wire logic B_CE,
   input wire logic B_CS,
   input wire logic B_WE,
   input wire logic B_OREG_EN,
   input wire logic [ebm_pkg::EBM_MAX_AW-1:0] B_ADDR,
   input wire logic [ebm_pkg::EBM_MAX_W-1:0] B_DIN,
   output logic [ebm_pkg::EBM_MAX_W-1:0] B_DOUT,
   input wire logic RD_STROBE,
   input wire logic [ebm_pkg::EBM_RK_W-1:0] RESET_REQ,
   output logic BUSY,
   output logic FULL_FLAG,
   output logic ALMOST_FULL_FLAG,
   output logic EMPTY_FLAG,
   output logic ALMOST_EMPTY_FLAG,
   ebm_if.user U
);
   import ebm_pkg::*;

   // ****************************************************************
   // Reset sequencer
   // ****************************************************************
   // Power-up walks a global reset through, so it is released before traffic
   ebm_seq_t state_reg; // [R20]
   ebm_seq_t state_next;
   logic [EBM_RK_W-1:0] kind_reg;
   logic [EBM_RK_W-1:0] kind_next;
   wire logic open = (state_reg == EBM_SEQ_IDLE);
   wire logic apply = (state_reg == EBM_SEQ_APPLY);

   always_comb
   begin
      state_next = state_reg;
      kind_next = kind_reg;
      case (state_reg)
         EBM_SEQ_IDLE:
         begin
            if (|RESET_REQ)
            begin
               state_next = EBM_SEQ_QUIET;
               kind_next = RESET_REQ;
            end
         end
         EBM_SEQ_QUIET: state_next = EBM_SEQ_APPLY; // [R18]
         EBM_SEQ_APPLY: state_next = EBM_SEQ_RELEASE;
         EBM_SEQ_RELEASE: state_next = EBM_SEQ_IDLE; // [R18]
         default: state_next = EBM_SEQ_IDLE;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         state_reg <= EBM_SEQ_APPLY;
         kind_reg <= EBM_RK_POWERUP;
      end else if (CE)
      begin
         state_reg <= state_next;
         kind_reg <= kind_next;
      end
   end

   // ****************************************************************
   // Request forwarding
   // ****************************************************************
   // Strobes count as enables, so they are closed with the enables too
   assign U.a_ce = A_CE & open; // [R18] [R21]
   assign U.a_cs = A_CS;
   assign U.a_we = A_WE & open; // [R21]
   assign U.a_oreg_en = A_OREG_EN & open;
   assign U.a_addr = A_ADDR;
   assign U.a_din = A_DIN;
   assign U.b_ce = B_CE & open;
   assign U.b_cs = B_CS;
   assign U.b_we = B_WE & open;
   assign U.b_oreg_en = B_OREG_EN & open;
   assign U.b_addr = B_ADDR;
   assign U.b_din = B_DIN;
   assign U.rd_strobe = RD_STROBE & open; // [R21]
   assign U.a_rst = apply & kind_reg[EBM_RK_A]; // [R19]
   assign U.b_rst = apply & kind_reg[EBM_RK_B];
   assign U.fifo_rst = apply & kind_reg[EBM_RK_FIFO];
   assign U.read_pointer_reset = apply & kind_reg[EBM_RK_RPTR];
   assign U.global_set_reset_n = ~(apply & kind_reg[EBM_RK_GLOBAL]);

   assign A_DOUT = U.a_dout;
   assign B_DOUT = U.b_dout;
   assign BUSY = ~open;
   assign FULL_FLAG = U.full_flag;
   assign ALMOST_FULL_FLAG = U.almost_full_flag;
   assign EMPTY_FLAG = U.empty_flag;
   assign ALMOST_EMPTY_FLAG = U.almost_empty_flag;
endmodule : ebm_user

/* File: tb/ebm_chk.sv */
// Checker for the link between the block memory and its user end.
// Assumes one clock, a synchronous active-low reset, and port widths A=9, B=4.
`timescale 1ns/1ps
module ebm_chk (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic a_ce,
   input wire logic a_cs,
   input wire logic a_we,
   input wire logic a_rst,
   input wire logic [ebm_pkg::EBM_MAX_W-1:0] a_dout,
   input wire logic b_ce,
   input wire logic b_cs,
   input wire logic b_we,
   input wire logic b_rst,
   input wire logic [ebm_pkg::EBM_MAX_W-1:0] b_din,
   input wire logic [ebm_pkg::EBM_MAX_W-1:0] b_dout,
   input wire logic rd_strobe,
   input wire logic global_set_reset_n
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // ****************************************************************
   // Reset sequencing on the wire
   // ****************************************************************
   quiet_before_a: assert property (
      ($rose(a_rst) || $rose(b_rst) || $fell(global_set_reset_n))
      |-> !$past(a_ce) && !$past(b_ce) && !$past(rd_strobe))
      else $error("enables not idle before reset");
   idle_during_a: assert property ((a_rst || b_rst || !global_set_reset_n)
      |-> !a_ce && !b_ce && !a_we && !b_we)
      else $error("enables active during reset");
   idle_after_a: assert property (
      ($rose(global_set_reset_n) || $fell(a_rst) || $fell(b_rst))
      |-> !a_ce && !b_ce)
      else $error("enables active right after reset");

   // ****************************************************************
   // Output latch clears
   // ****************************************************************
   global_clear_a: assert property (CE && !global_set_reset_n
      |=> a_dout == 18'h00000 && b_dout == 18'h00000)
      else $error("global reset left a latch set");
   a_clear_a: assert property (CE && a_rst |=> a_dout == 18'h00000)
      else $error("port A latch not cleared");
   b_clear_a: assert property (CE && b_rst |=> b_dout == 18'h00000)
      else $error("port B latch not cleared");

   // ****************************************************************
   // Write behaviour and unused bits
   // ****************************************************************
   // The latch moves one edge after the request edge, so stability is judged two edges on
   normal_hold_a: assert property (
      CE && a_ce && a_cs && a_we ##1 CE && !a_rst && global_set_reset_n
      |-> ##1 $stable(a_dout))
      else $error("normal write changed port A output");
   through_b_a: assert property (CE && b_ce && b_cs && b_we ##1 CE
      |-> ##1 b_dout == {14'h0000, $past(b_din[3:0], 2)})
      else $error("write-through data missing on port B");
   deselect_a: assert property (CE && !a_cs ##1 CE && !a_rst && global_set_reset_n
      |-> ##1 $stable(a_dout))
      else $error("deselected port A changed output");
   upper_zero_a: assert property (a_dout[17:9] == 9'h000 && b_dout[17:4] == 14'h0000)
      else $error("bits above port width not zero");

   cover property (CE && a_rst);
   cover property (CE && b_ce && b_cs && b_we);
   cover property (CE && !global_set_reset_n);
endmodule : ebm_chk

/* File: tb/tb_top.sv */
// Testbench joining the block memory and its user end, driving the user side.
// Assumes port A 9 bits normal mode, port B 4 bits write-through, true dual port.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
   import ebm_pkg::*;
   logic clk, ce, rst_n, a_ce, a_cs, a_we, b_ce, b_cs, b_we, rd_strobe, a_oreg, b_oreg;
   logic [EBM_MAX_AW-1:0] a_addr, b_addr;
   logic [EBM_MAX_W-1:0] a_din, b_din, a_dout, b_dout;
   logic [EBM_RK_W-1:0] reset_req;
   logic busy, full, afull, empty, aempty;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;

   // ****************************************************************
   // Both ends and the checker
   // ****************************************************************
   ebm_if ebm_if_inst ();
   ebm_mem #(.MODE(EBM_TDP), .A_WIDTH(9), .B_WIDTH(4), .B_WMODE(EBM_WR_THROUGH)) ebm_mem_inst (
      .CLK(clk), .CE(ce), .RST_N(rst_n), .M(ebm_if_inst));
   ebm_user ebm_user_inst (.CLK(clk), .CE(ce), .RST_N(rst_n), .A_CE(a_ce), .A_CS(a_cs),
      .A_WE(a_we), .A_OREG_EN(a_oreg), .A_ADDR(a_addr), .A_DIN(a_din), .A_DOUT(a_dout),
      .B_CE(b_ce), .B_CS(b_cs), .B_WE(b_we), .B_OREG_EN(b_oreg), .B_ADDR(b_addr),
      .B_DIN(b_din), .B_DOUT(b_dout), .RD_STROBE(rd_strobe), .RESET_REQ(reset_req),
      .BUSY(busy), .FULL_FLAG(full), .ALMOST_FULL_FLAG(afull), .EMPTY_FLAG(empty),
      .ALMOST_EMPTY_FLAG(aempty), .U(ebm_if_inst));
   ebm_chk ebm_chk_inst (.CLK(clk), .RST_N(rst_n), .CE(ce), .a_ce(ebm_if_inst.a_ce),
      .a_cs(ebm_if_inst.a_cs), .a_we(ebm_if_inst.a_we), .a_rst(ebm_if_inst.a_rst),
      .a_dout(ebm_if_inst.a_dout), .b_ce(ebm_if_inst.b_ce), .b_cs(ebm_if_inst.b_cs),
      .b_we(ebm_if_inst.b_we), .b_rst(ebm_if_inst.b_rst), .b_din(ebm_if_inst.b_din),
      .b_dout(ebm_if_inst.b_dout), .rd_strobe(ebm_if_inst.rd_strobe),
      .global_set_reset_n(ebm_if_inst.global_set_reset_n));

   always #20 clk = ~clk;

   // Run is about 116 cycles; the ceiling only catches a hang
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         close_out();
      end
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic close_out();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // One request on port A or B, then time for the latch to settle
   task automatic ram_op(input logic pb, input logic cs, input logic we,
                         input logic [12:0] ad, input logic [17:0] d);
      @(negedge clk);
      a_ce = !pb;
      b_ce = pb;
      a_cs = cs;
      b_cs = cs;
      a_we = we & !pb;
      b_we = we & pb;
      a_addr = ad;
      b_addr = ad;
      a_din = d;
      b_din = d;
      @(negedge clk);
      a_ce = 1'b0;
      b_ce = 1'b0;
      a_we = 1'b0;
      b_we = 1'b0;
      repeat (3) @(negedge clk);
   endtask : ram_op

   task automatic do_reset(input logic [4:0] k);
      int i;
      @(negedge clk);
      reset_req = k;
      @(negedge clk);
      reset_req = 5'h00;
      for (i = 0; i < 20 && busy !== 1'b0; i++)
         @(negedge clk);
      `CHK("busy", 1'b0, busy)
      repeat (2) @(negedge clk);
   endtask : do_reset

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_power();
      `CHK("a_dout power", 18'h00000, a_dout)
      `CHK("b_dout power", 18'h00000, b_dout)
      `CHK("flags idle", 4'h3, {full, afull, empty, aempty})
   endtask : t_power

   task automatic t_normal();
      ram_op(1'b0, 1'b1, 1'b1, 13'h0000, 18'h001a5);
      ram_op(1'b0, 1'b1, 1'b1, 13'h0001, 18'h000c3);
      ram_op(1'b0, 1'b1, 1'b0, 13'h0000, 18'h00000);
      `CHK("a read 0", 18'h001a5, a_dout)
      ram_op(1'b0, 1'b1, 1'b1, 13'h0003, 18'h001ff);
      `CHK("a after write", 18'h001a5, a_dout)
   endtask : t_normal

   // Narrow words of B laid over the 9-bit words of A
   task automatic t_widths();
      logic [3:0] exp [3];
      exp = '{4'h5, 4'ha, 4'h7};
      for (int i = 0; i < 3; i++)
      begin
         ram_op(1'b1, 1'b1, 1'b0, i[12:0], 18'h00000);
         `CHK("b narrow read", {14'h0000, exp[i]}, b_dout)
      end
   endtask : t_widths

   task automatic t_through();
      ram_op(1'b1, 1'b1, 1'b1, 13'h0005, 18'h00009);
      `CHK("b through", 18'h00009, b_dout)
      ram_op(1'b0, 1'b1, 1'b0, 13'h0002, 18'h00000);
      `CHK("a sees b word", 18'h00024, a_dout)
   endtask : t_through

   task automatic t_resets();
      do_reset(5'h01);
      `CHK("a after a reset", 18'h00000, a_dout)
      `CHK("b after a reset", 18'h00009, b_dout)
      do_reset(5'h02);
      `CHK("b after b reset", 18'h00000, b_dout)
      ram_op(1'b0, 1'b1, 1'b0, 13'h0000, 18'h00000);
      ram_op(1'b1, 1'b1, 1'b1, 13'h0005, 18'h00003);
      do_reset(5'h10);
      `CHK("a after global", 18'h00000, a_dout)
      `CHK("b after global", 18'h00000, b_dout)
      ram_op(1'b0, 1'b1, 1'b0, 13'h0000, 18'h00000);
      `CHK("array kept", 18'h001a5, a_dout)
   endtask : t_resets

   task automatic t_select();
      ram_op(1'b0, 1'b0, 1'b1, 13'h0000, 18'h00000);
      ram_op(1'b0, 1'b1, 1'b0, 13'h0000, 18'h00000);
      `CHK("deselected write", 18'h001a5, a_dout)
   endtask : t_select

   initial
   begin
      clk = 1'b0;
      ce = 1'b1;
      rst_n = 1'b0;
      {a_ce, a_cs, a_we, b_ce, b_cs, b_we, rd_strobe, a_oreg, b_oreg} = 9'h000;
      a_addr = '0;
      b_addr = '0;
      a_din = '0;
      b_din = '0;
      reset_req = 5'h00;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (5) @(negedge clk);
      t_power();
      t_normal();
      t_widths();
      t_through();
      t_resets();
      t_select();
      close_out();
   end
endmodule : tb_top
